// file: flag_ops.sv
// Status-flag, bit-transfer and control instruction block with Avalon-MM slave
//
// Behaviour
// - bit_to_transfer_flag copies chosen register bit into T, only T changes, one cycle.
// - transfer_flag_to_bit writes T into chosen register bit, flags unchanged, one cycle.
// - set_sign_flag / clear_sign_flag force S to one / zero, nothing else.
// - set_overflow_flag / clear_overflow_flag force V to one / zero, nothing else.
// - set_half_carry_flag / clear_half_carry_flag force H to one / zero, nothing else.
// - Sleep takes one cycle, keeps flags, raises a sleep request pulse.
// - watchdog_restart takes one cycle, keeps flags, raises a restart pulse.
`timescale 1ns/1ns
`default_nettype none
module flag_ops (
    // Clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 rst_b_in,
    // Register bus
    input  wire flag_ops_pkg::av_req_t av_in,
    output var  flag_ops_pkg::av_rsp_t av_out,
    // Control pulses to sleep and watchdog logic
    output var  logic                 sleep_req_out,
    output var  logic                 wdt_restart_out
);
    import flag_ops_pkg::*;

    typedef struct packed {
        logic [7:0]       flags;
        logic [31:0][7:0] gpr;
        logic [4:0]       sel;
        logic             waitreq;
        logic [31:0]      rdata;
        logic             sleep;
        logic             restart;
    } state_t;

    state_t q_r;
    state_t q_nxt;
    logic   rst_meta_r;
    logic   rst_sync_r;

    function automatic logic pick_bit(input logic [7:0] val, input logic [2:0] idx);
        pick_bit = val[idx];
    endfunction

    // All ones except the flag one instruction owns; proves the other flags stay put
    function automatic logic [7:0] keep_mask(input int pos);
        keep_mask      = 8'hff;
        keep_mask[pos] = 1'b0;
    endfunction

    // Reset release through two flip-flops
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    logic       req;
    logic       accept;
    logic [4:0] op;
    logic [4:0] reg_idx;
    logic [2:0] bit_idx;

    assign req     = av_in.read | av_in.write;
    // Answer one cycle after the request appears; waitrequest drops for exactly that cycle
    assign accept  = req & ~q_r.waitreq;
    assign op      = av_in.writedata[CMD_OP_LSB +: 5];
    assign reg_idx = av_in.writedata[CMD_REG_LSB +: 5];
    assign bit_idx = av_in.writedata[CMD_BIT_LSB +: 3];

    always_comb begin
        q_nxt       = q_r;
        q_nxt.sleep = 1'b0;
        q_nxt.restart = 1'b0;
        q_nxt.waitreq = ~(req & q_r.waitreq);
        if (req & q_r.waitreq) begin
            case (av_in.address)
                OFS_STATUS:   q_nxt.rdata = {24'h000000, q_r.flags};
                OFS_GPR_SEL:  q_nxt.rdata = {27'h0000000, q_r.sel};
                OFS_GPR_DATA: q_nxt.rdata = {24'h000000, q_r.gpr[q_r.sel]};
                default:      q_nxt.rdata = 32'h00000000;
            endcase
        end
        if (accept & av_in.write) begin
            case (av_in.address)
                OFS_STATUS:   q_nxt.flags = av_in.writedata[7:0];
                OFS_GPR_SEL:  q_nxt.sel = av_in.writedata[4:0];
                OFS_GPR_DATA: q_nxt.gpr[q_r.sel] = av_in.writedata[7:0];
                // Every instruction completes at the accepting edge, so each costs one cycle
                OFS_COMMAND: begin
                    case (op)
                        OP_BIT_TO_TRANSFER_FLAG:  q_nxt.flags[FLAG_T] = pick_bit(q_r.gpr[reg_idx], bit_idx);
                        OP_TRANSFER_FLAG_TO_BIT:  q_nxt.gpr[reg_idx][bit_idx] = q_r.flags[FLAG_T];
                        OP_SET_SIGN_FLAG:         q_nxt.flags[FLAG_S] = 1'b1;
                        OP_CLEAR_SIGN_FLAG:       q_nxt.flags[FLAG_S] = 1'b0;
                        OP_SET_OVERFLOW_FLAG:     q_nxt.flags[FLAG_V] = 1'b1;
                        OP_CLEAR_OVERFLOW_FLAG:   q_nxt.flags[FLAG_V] = 1'b0;
                        OP_SET_HALF_CARRY_FLAG:   q_nxt.flags[FLAG_H] = 1'b1;
                        OP_CLEAR_HALF_CARRY_FLAG: q_nxt.flags[FLAG_H] = 1'b0;
                        OP_SLEEP:                 q_nxt.sleep = 1'b1;
                        OP_WATCHDOG_RESTART:      q_nxt.restart = 1'b1;
                        OP_SET_CARRY_FLAG:        q_nxt.flags[FLAG_C] = 1'b1;
                        OP_CLEAR_CARRY_FLAG:      q_nxt.flags[FLAG_C] = 1'b0;
                        OP_SET_NEGATIVE_FLAG:     q_nxt.flags[FLAG_N] = 1'b1;
                        OP_CLEAR_NEGATIVE_FLAG:   q_nxt.flags[FLAG_N] = 1'b0;
                        OP_SET_ZERO_FLAG:         q_nxt.flags[FLAG_Z] = 1'b1;
                        OP_CLEAR_ZERO_FLAG:       q_nxt.flags[FLAG_Z] = 1'b0;
                        OP_GLOBAL_INTERRUPT_ON:   q_nxt.flags[FLAG_I] = 1'b1;
                        OP_GLOBAL_INTERRUPT_OFF:  q_nxt.flags[FLAG_I] = 1'b0;
                        OP_SET_TRANSFER_FLAG:     q_nxt.flags[FLAG_T] = 1'b1;
                        OP_CLEAR_TRANSFER_FLAG:   q_nxt.flags[FLAG_T] = 1'b0;
                        // Unknown codes behave as no_operation rather than trapping
                        default:                  q_nxt.flags = q_r.flags;
                    endcase
                end
                default: q_nxt.flags = q_r.flags;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            q_r.flags   <= STATUS_RST;
            q_r.gpr     <= {32{GPR_RST}};
            q_r.sel     <= 5'h00;
            q_r.waitreq <= 1'b1;
            q_r.rdata   <= 32'h00000000;
            q_r.sleep   <= 1'b0;
            q_r.restart <= 1'b0;
        end else begin
            q_r <= q_nxt;
        end
    end

    // One assignment for the whole struct keeps a single driver on the bus response
    assign av_out          = '{waitrequest: q_r.waitreq, readdata: q_r.rdata};
    assign sleep_req_out   = q_r.sleep;
    assign wdt_restart_out = q_r.restart;

    // Checks
    logic cmd_go;
    assign cmd_go = accept & av_in.write & (av_in.address == OFS_COMMAND);

    sequence s_cmd(logic [4:0] code);
        cmd_go && op == code;
    endsequence

    // Bus answer: request seen with waitrequest high, which then drops for one cycle
    sequence s_answer;
        av_out.waitrequest ##1 !av_out.waitrequest;
    endsequence

    AST_BIT_TO_T: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
        s_cmd(OP_BIT_TO_TRANSFER_FLAG) |=> q_r.flags[FLAG_T] == pick_bit($past(q_r.gpr[reg_idx]), $past(bit_idx))
            && (q_r.flags & keep_mask(FLAG_T)) == ($past(q_r.flags) & keep_mask(FLAG_T)))
        else $error("bit to T copy wrong");
    AST_T_TO_BIT: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
        s_cmd(OP_TRANSFER_FLAG_TO_BIT) |=> q_r.gpr[$past(reg_idx)][$past(bit_idx)] == $past(q_r.flags[FLAG_T])
            && $stable(q_r.flags))
        else $error("T to bit copy wrong");
    AST_SIGN: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
        s_cmd(OP_SET_SIGN_FLAG) or s_cmd(OP_CLEAR_SIGN_FLAG) |=>
            q_r.flags[FLAG_S] == ($past(op) == OP_SET_SIGN_FLAG)
            && (q_r.flags & keep_mask(FLAG_S)) == ($past(q_r.flags) & keep_mask(FLAG_S)))
        else $error("sign flag wrong");
    AST_OVF: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
        s_cmd(OP_SET_OVERFLOW_FLAG) or s_cmd(OP_CLEAR_OVERFLOW_FLAG) |=>
            q_r.flags[FLAG_V] == ($past(op) == OP_SET_OVERFLOW_FLAG)
            && (q_r.flags & keep_mask(FLAG_V)) == ($past(q_r.flags) & keep_mask(FLAG_V)))
        else $error("overflow flag wrong");
    AST_HALF: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
        s_cmd(OP_SET_HALF_CARRY_FLAG) or s_cmd(OP_CLEAR_HALF_CARRY_FLAG) |=>
            q_r.flags[FLAG_H] == ($past(op) == OP_SET_HALF_CARRY_FLAG)
            && (q_r.flags & keep_mask(FLAG_H)) == ($past(q_r.flags) & keep_mask(FLAG_H)))
        else $error("half carry flag wrong");
    AST_CARRY: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
        s_cmd(OP_SET_CARRY_FLAG) or s_cmd(OP_CLEAR_CARRY_FLAG) |=>
            q_r.flags[FLAG_C] == ($past(op) == OP_SET_CARRY_FLAG)
            && (q_r.flags & keep_mask(FLAG_C)) == ($past(q_r.flags) & keep_mask(FLAG_C)))
        else $error("carry flag wrong");
    AST_NEG: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
        s_cmd(OP_SET_NEGATIVE_FLAG) or s_cmd(OP_CLEAR_NEGATIVE_FLAG) |=>
            q_r.flags[FLAG_N] == ($past(op) == OP_SET_NEGATIVE_FLAG)
            && (q_r.flags & keep_mask(FLAG_N)) == ($past(q_r.flags) & keep_mask(FLAG_N)))
        else $error("negative flag wrong");
    AST_ZERO: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
        s_cmd(OP_SET_ZERO_FLAG) or s_cmd(OP_CLEAR_ZERO_FLAG) |=>
            q_r.flags[FLAG_Z] == ($past(op) == OP_SET_ZERO_FLAG)
            && (q_r.flags & keep_mask(FLAG_Z)) == ($past(q_r.flags) & keep_mask(FLAG_Z)))
        else $error("zero flag wrong");
    AST_INTR: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
        s_cmd(OP_GLOBAL_INTERRUPT_ON) or s_cmd(OP_GLOBAL_INTERRUPT_OFF) |=>
            q_r.flags[FLAG_I] == ($past(op) == OP_GLOBAL_INTERRUPT_ON)
            && (q_r.flags & keep_mask(FLAG_I)) == ($past(q_r.flags) & keep_mask(FLAG_I)))
        else $error("interrupt flag wrong");
    AST_TFLAG: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
        s_cmd(OP_SET_TRANSFER_FLAG) or s_cmd(OP_CLEAR_TRANSFER_FLAG) |=>
            q_r.flags[FLAG_T] == ($past(op) == OP_SET_TRANSFER_FLAG)
            && (q_r.flags & keep_mask(FLAG_T)) == ($past(q_r.flags) & keep_mask(FLAG_T)))
        else $error("transfer flag wrong");
    AST_SLEEP: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
        s_cmd(OP_SLEEP) |=> sleep_req_out && $stable(q_r.flags) ##1 !sleep_req_out)
        else $error("sleep pulse wrong");
    AST_SLEEP_SRC: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
        sleep_req_out |-> $past(cmd_go) && $past(op) == OP_SLEEP)
        else $error("sleep pulse without sleep command");
    AST_RESTART: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
        s_cmd(OP_WATCHDOG_RESTART) |=> wdt_restart_out && $stable(q_r.flags) ##1 !wdt_restart_out)
        else $error("watchdog pulse wrong");
    AST_RESTART_SRC: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
        wdt_restart_out |-> $past(cmd_go) && $past(op) == OP_WATCHDOG_RESTART)
        else $error("restart pulse without restart command");
    AST_NOP: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
        s_cmd(OP_NO_OPERATION) |=> $stable(q_r.flags) && $stable(q_r.gpr) && !sleep_req_out && !wdt_restart_out)
        else $error("no operation changed state");
    AST_UNKNOWN: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
        cmd_go && op > OP_WATCHDOG_RESTART |=>
            $stable(q_r.flags) && $stable(q_r.gpr) && !sleep_req_out && !wdt_restart_out)
        else $error("unused code changed state");
    AST_WAIT: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
        $rose(req) |-> s_answer)
        else $error("bus answer not in one cycle");
    AST_WAIT_ONE: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
        !av_out.waitrequest |=> av_out.waitrequest)
        else $error("waitrequest low for more than one cycle");
endmodule // flag_ops
`default_nettype wire

// file: flag_ops_pkg.sv
// Constants and types shared by the status-flag instruction block
`default_nettype none
package flag_ops_pkg;
    // Register byte offsets
    localparam logic [3:0] OFS_STATUS   = 4'h0;
    localparam logic [3:0] OFS_COMMAND  = 4'h4;
    localparam logic [3:0] OFS_GPR_SEL  = 4'h8;
    localparam logic [3:0] OFS_GPR_DATA = 4'hc;
    // Reset values
    localparam logic [7:0] STATUS_RST   = 8'h00;
    localparam logic [7:0] GPR_RST      = 8'h00;
    // Flag positions inside the status flags register
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    // Command word fields
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_REG_LSB = 8;
    localparam int CMD_BIT_LSB = 16;
    // Cycles that each instruction occupies
    localparam int INSN_CYCLES = 1;
    // Instruction codes
    localparam logic [4:0] OP_NO_OPERATION           = 5'h00;
    localparam logic [4:0] OP_BIT_TO_TRANSFER_FLAG   = 5'h01;
    localparam logic [4:0] OP_TRANSFER_FLAG_TO_BIT   = 5'h02;
    localparam logic [4:0] OP_SET_CARRY_FLAG         = 5'h03;
    localparam logic [4:0] OP_CLEAR_CARRY_FLAG       = 5'h04;
    localparam logic [4:0] OP_SET_NEGATIVE_FLAG      = 5'h05;
    localparam logic [4:0] OP_CLEAR_NEGATIVE_FLAG    = 5'h06;
    localparam logic [4:0] OP_SET_ZERO_FLAG          = 5'h07;
    localparam logic [4:0] OP_CLEAR_ZERO_FLAG        = 5'h08;
    localparam logic [4:0] OP_GLOBAL_INTERRUPT_ON    = 5'h09;
    localparam logic [4:0] OP_GLOBAL_INTERRUPT_OFF   = 5'h0a;
    localparam logic [4:0] OP_SET_SIGN_FLAG          = 5'h0b;
    localparam logic [4:0] OP_CLEAR_SIGN_FLAG        = 5'h0c;
    localparam logic [4:0] OP_SET_OVERFLOW_FLAG      = 5'h0d;
    localparam logic [4:0] OP_CLEAR_OVERFLOW_FLAG    = 5'h0e;
    localparam logic [4:0] OP_SET_TRANSFER_FLAG      = 5'h0f;
    localparam logic [4:0] OP_CLEAR_TRANSFER_FLAG    = 5'h10;
    localparam logic [4:0] OP_SET_HALF_CARRY_FLAG    = 5'h11;
    localparam logic [4:0] OP_CLEAR_HALF_CARRY_FLAG  = 5'h12;
    localparam logic [4:0] OP_SLEEP                  = 5'h13;
    localparam logic [4:0] OP_WATCHDOG_RESTART       = 5'h14;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
    } av_req_t;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } av_rsp_t;
endpackage
`default_nettype wire

// file: insn_issue_model.sv
// Bus master standing in for the instruction fetch stage
`timescale 1ns/1ns
`default_nettype none
module insn_issue_model (
    // Clock
    input  wire logic                  clk_in,
    // Bus towards the block
    output var  flag_ops_pkg::av_req_t req_out,
    input  wire flag_ops_pkg::av_rsp_t rsp_in
);
    import flag_ops_pkg::*;
    initial req_out = '0;
    // Request stays put until waitrequest is sampled low, so no transfer is lost
    task automatic access(input logic wr, input logic [3:0] addr, input logic [31:0] wdata,
                          output logic [31:0] rdata);
        @(posedge clk_in);
        req_out <= '{read: ~wr, write: wr, address: addr, writedata: wdata};
        @(posedge clk_in);
        while (rsp_in.waitrequest !== 1'b0) @(posedge clk_in);
        rdata = rsp_in.readdata;
        req_out <= '0;
    endtask
endmodule // insn_issue_model
`default_nettype wire

// file: flag_ops_tb_top.sv
// Randomised self-checking bench for the status-flag instruction block
`timescale 1ns/1ns
`default_nettype none
module flag_ops_tb_top;
    import flag_ops_pkg::*;
    logic        clk_in;
    logic        rst_b_in;
    av_req_t     av_req;
    av_rsp_t     av_rsp;
    logic        sleep_req;
    logic        wdt_restart;
    int          bad_count;
    int          checked;
    int          cycles;
    int          seed;
    logic [31:0] rd;
    logic [7:0]  s, g, es, eg;
    logic [4:0]  r;
    logic [2:0]  b;
    // Flag owned by each set/clear pair, codes 0x03 upward
    int          pos [8] = '{FLAG_C, FLAG_N, FLAG_Z, FLAG_I, FLAG_S, FLAG_V, FLAG_T, FLAG_H};

    flag_ops i_flag_ops (.clk_in(clk_in), .rst_b_in(rst_b_in), .av_in(av_req), .av_out(av_rsp),
        .sleep_req_out(sleep_req), .wdt_restart_out(wdt_restart));
    insn_issue_model i_insn_issue_model (.clk_in(clk_in), .req_out(av_req), .rsp_in(av_rsp));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    function automatic logic [15:0] expect_state(input int op, input logic [2:0] bi,
                                                 input logic [7:0] gv, input logic [7:0] sv);
        logic [7:0] xs;
        logic [7:0] xg;
        xs = sv;
        xg = gv;
        if (op == 1) xs[FLAG_T] = gv[bi];
        if (op == 2) xg[bi] = sv[FLAG_T];
        if (op >= 3 && op <= 18) xs[pos[(op - 3) / 2]] = op[0];
        return {xg, xs};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        i_insn_issue_model.access(1'b1, a, d, rd);
    endtask

    task automatic rdc(input string what, input logic [3:0] a, input logic [31:0] exp);
        i_insn_issue_model.access(1'b0, a, 32'h0, rd);
        chk(what, exp, rd);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // A hung handshake ends here rather than running forever
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            print_verdict;
        end
    end

    initial begin
        seed = 35169;
        bad_count = 0;
        checked = 0;
        rst_b_in = 1'b0;
        repeat (20) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rdc("status after reset", OFS_STATUS, {24'h0, STATUS_RST});
        rdc("register after reset", OFS_GPR_DATA, {24'h0, GPR_RST});
        rdc("command readback", OFS_COMMAND, 32'h0);
        rdc("unmapped read", 4'h2, 32'h0);
        // Every code plus one unused code, three random passes
        for (int pass = 0; pass < 3; pass++) begin
            for (int op = 0; op < 22; op++) begin
                {r, b, g, s} = 24'($random(seed));
                wr(OFS_GPR_SEL, {27'h0, r});
                wr(OFS_GPR_DATA, {24'h0, g});
                wr(OFS_STATUS, {24'h0, s});
                wr(OFS_COMMAND, {13'h0, b, 3'h0, r, 3'h0, (op == 21) ? 5'h1f : 5'(op)});
                #1;
                chk("sleep pulse", {31'h0, op == 19}, {31'h0, sleep_req});
                chk("restart pulse", {31'h0, op == 20}, {31'h0, wdt_restart});
                repeat (INSN_CYCLES) @(posedge clk_in);
                #1;
                chk("pulse width", 32'h0, {30'h0, sleep_req, wdt_restart});
                {eg, es} = expect_state(op, b, g, s);
                rdc("status", OFS_STATUS, {24'h0, es});
                rdc("register", OFS_GPR_DATA, {24'h0, eg});
                rdc("select", OFS_GPR_SEL, {27'h0, r});
            end
        end
        // Mid-run reset must clear the flags, the register file and the select
        wr(OFS_GPR_SEL, 32'h0);
        wr(OFS_GPR_DATA, 32'h000000a5);
        wr(OFS_STATUS, 32'h000000ff);
        rst_b_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rdc("status after second reset", OFS_STATUS, {24'h0, STATUS_RST});
        rdc("select after second reset", OFS_GPR_SEL, 32'h0);
        rdc("register after second reset", OFS_GPR_DATA, {24'h0, GPR_RST});
        print_verdict;
    end
endmodule // flag_ops_tb_top
`default_nettype wire
